/* inc/tmr_consts.svh */
// What this block does
// - two 16-bit compare registers, reset all ones
// - second register writable only in pulse mode
// - 8-bit control register, fields, resets to zero
// - bit 6 meaning depends on operating mode
// - start control: stop/clear, command, edge selects
// - source clock: fc divisions, fs/8, pin
// - operating mode: timer, window, width, pulse
// - double buffer loads on source tick after high
// - stop power mode clears start control
// - auto-capture copies counter every source tick while counting
`ifndef TMR_CONSTS_SVH
`define TMR_CONSTS_SVH

// ==========================================================
// register byte addresses
`define TMR_ADDR_A_LOW   8'h10
`define TMR_ADDR_A_HIGH  8'h11
`define TMR_ADDR_B_LOW   8'h12
`define TMR_ADDR_B_HIGH  8'h13
`define TMR_ADDR_CTRL    8'h26

// ==========================================================
// reset values
`define TMR_CMP_RESET    16'hffff
`define TMR_CTRL_RESET   8'h00
`define TMR_RDATA_NONE   8'h00

// ==========================================================
// control field positions
`define TMR_FF_BIT       7
`define TMR_OPT_BIT      6
`define TMR_START_HI     5
`define TMR_START_LO     4
`define TMR_SRC_HI       3
`define TMR_SRC_LO       2
`define TMR_MODE_HI      1
`define TMR_MODE_LO      0

// ==========================================================
// divider taps (fc/2^11, fc/2^7, fc/2^3, fs/2^3)
`define TMR_DIV_W        11
`define TMR_TAP_SLOW     11'h7ff
`define TMR_TAP_MID      11'h07f
`define TMR_TAP_FAST     11'h007
`define TMR_FS_W         3
`define TMR_FS_TAP       3'h7
`define TMR_CNT_ONE      16'h0001
`define TMR_CNT_ZERO     16'h0000

`endif

/* inc/tmr_pkg.sv */
// ==========================================================
// shared encodings of the timer control fields
package tmr_pkg;

  // operating mode select
  typedef enum logic [1:0] {
    TMR_MODE_TIMER = 2'b00,
    TMR_MODE_WINDOW = 2'b01,
    TMR_MODE_WIDTH = 2'b10,
    TMR_MODE_PULSE = 2'b11
  } tmr_mode_e;

  // start control
  typedef enum logic [1:0] {
    TMR_START_STOP = 2'b00,
    TMR_START_CMD = 2'b01,
    TMR_START_RISE = 2'b10,
    TMR_START_FALL = 2'b11
  } tmr_start_e;

  // source clock select
  typedef enum logic [1:0] {
    TMR_SRC_SLOW = 2'b00,
    TMR_SRC_MID = 2'b01,
    TMR_SRC_FAST = 2'b10,
    TMR_SRC_PIN = 2'b11
  } tmr_src_e;

endpackage : tmr_pkg

/* hw/tmr_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tmr_consts.svh"

module tmr_ctrl (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        resetn_i,
  // register port
  input  wire logic [7:0]  addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [7:0]  rdata_o,
  // chip level conditions
  input  wire logic        timer_input_pin_i,
  input  wire logic        fs_tick_i,
  input  wire logic        low_speed_divider_option_i,
  input  wire logic        slow_mode_i,
  input  wire logic        stop_mode_enter_i,
  // timer state
  output logic      [15:0] compare_a_o,
  output logic      [15:0] compare_b_o,
  output logic      [15:0] counter_o,
  output logic             source_tick_o,
  output logic             programmable_pulse_output_o
);

  // ==========================================================
  // helpers
  function automatic logic hit(input logic en, input logic [7:0] a, input logic [7:0] ref_a);
    hit = en && (a == ref_a);
  endfunction : hit

  // ==========================================================
  // control register and fields
  logic [7:0]  ctrl_q;
  logic        flipflop_control;
  logic        mode_option;
  logic [1:0]  start_control;
  logic [1:0]  source_clock_select;
  logic [1:0]  operating_mode_select;
  logic        pulse_mode;
  logic        capture_mode;
  logic        auto_capture_enable;
  logic        capture_edge_select;
  logic        trigger_stop_select;
  logic        one_shot_select;
  logic        running;

  // field split
  assign flipflop_control      = ctrl_q[`TMR_FF_BIT];
  assign mode_option           = ctrl_q[`TMR_OPT_BIT];
  assign start_control         = ctrl_q[`TMR_START_HI:`TMR_START_LO];
  assign source_clock_select   = ctrl_q[`TMR_SRC_HI:`TMR_SRC_LO];
  assign operating_mode_select = ctrl_q[`TMR_MODE_HI:`TMR_MODE_LO];

  // mode decode
  assign pulse_mode   = operating_mode_select == tmr_pkg::TMR_MODE_PULSE;
  assign capture_mode = (operating_mode_select == tmr_pkg::TMR_MODE_TIMER) ||
                        (operating_mode_select == tmr_pkg::TMR_MODE_WINDOW);

  // option bit read per mode
  assign auto_capture_enable = mode_option && capture_mode;
  assign capture_edge_select = mode_option && (operating_mode_select == tmr_pkg::TMR_MODE_WIDTH);
  assign trigger_stop_select = mode_option && (operating_mode_select == tmr_pkg::TMR_MODE_TIMER);
  assign one_shot_select     = mode_option && pulse_mode;

  // any start code but stop lets the counter advance
  assign running = start_control != tmr_pkg::TMR_START_STOP;

  // ==========================================================
  // address decode
  logic wr_a_low;
  logic wr_a_high;
  logic wr_b_low;
  logic wr_b_high;
  logic wr_ctrl;

  assign wr_a_low  = hit(wr_i, addr_i, `TMR_ADDR_A_LOW);
  assign wr_a_high = hit(wr_i, addr_i, `TMR_ADDR_A_HIGH);
  assign wr_b_low  = hit(wr_i, addr_i, `TMR_ADDR_B_LOW) && pulse_mode;
  assign wr_b_high = hit(wr_i, addr_i, `TMR_ADDR_B_HIGH) && pulse_mode;
  assign wr_ctrl   = hit(wr_i, addr_i, `TMR_ADDR_CTRL);

  // control register; stop entry overrides a write in the same cycle
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_q <= `TMR_CTRL_RESET;
    end else if (stop_mode_enter_i) begin
      ctrl_q[`TMR_START_HI:`TMR_START_LO] <= tmr_pkg::TMR_START_STOP;
    end else if (wr_ctrl) begin
      ctrl_q <= wdata_i;
    end
  end

  // ==========================================================
  // source clock generation
  logic [`TMR_DIV_W-1:0] div_q;
  logic [`TMR_FS_W-1:0]  fs_div_q;
  logic                  pin_q;
  logic                  pin_rise;
  logic                  pin_fall;
  logic                  pin_edge;
  logic                  use_fs;
  logic                  src_tick;

  // free-running fc divider
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + `TMR_DIV_W'(1);
    end
  end

  // fs/2^3 divider on the low-speed enable
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fs_div_q <= '0;
    end else if (fs_tick_i) begin
      fs_div_q <= fs_div_q + `TMR_FS_W'(1);
    end
  end

  // pin history for edge detection
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= timer_input_pin_i;
    end
  end

  assign pin_rise = timer_input_pin_i && !pin_q;
  assign pin_fall = !timer_input_pin_i && pin_q;
  // falling start code picks the falling edge, else rising
  assign pin_edge = (start_control == tmr_pkg::TMR_START_FALL) ? pin_fall : pin_rise;
  assign use_fs   = low_speed_divider_option_i || slow_mode_i;

  // source clock select
  always_comb begin
    case (source_clock_select)
      tmr_pkg::TMR_SRC_SLOW: begin
        src_tick = use_fs ? (fs_tick_i && (fs_div_q == `TMR_FS_TAP))
                          : (div_q == `TMR_TAP_SLOW);
      end
      tmr_pkg::TMR_SRC_MID: begin
        src_tick = div_q[6:0] == 7'(`TMR_TAP_MID);
      end
      tmr_pkg::TMR_SRC_FAST: begin
        src_tick = div_q[2:0] == 3'(`TMR_TAP_FAST);
      end
      tmr_pkg::TMR_SRC_PIN: begin
        src_tick = pin_edge;
      end
      default: begin
        src_tick = 1'b0;
      end
    endcase
  end

  // tick is visible for the outside
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      source_tick_o <= 1'b0;
    end else begin
      source_tick_o <= src_tick;
    end
  end

  // ==========================================================
  // compare a: write buffer and active value
  logic [15:0] buf_a_q;
  logic        pend_a_q;

  // low byte only fills the buffer
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      buf_a_q <= `TMR_CMP_RESET;
    end else if (wr_a_low) begin
      buf_a_q[7:0] <= wdata_i;
    end else if (wr_a_high) begin
      buf_a_q[15:8] <= wdata_i;
    end
  end

  // high byte arms the load; a new high write wins over the tick
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pend_a_q <= 1'b0;
    end else if (wr_a_high) begin
      pend_a_q <= 1'b1;
    end else if (src_tick) begin
      pend_a_q <= 1'b0;
    end
  end

  // active value moves on the first tick after the high byte
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      compare_a_o <= `TMR_CMP_RESET;
    end else if (pend_a_q && src_tick) begin
      compare_a_o <= buf_a_q;
    end
  end

  // ==========================================================
  // compare/capture b
  logic [15:0] buf_b_q;
  logic        pend_b_q;
  logic        capture_now;

  // auto-capture on every source tick while counting
  assign capture_now = auto_capture_enable && running && src_tick;

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      buf_b_q <= `TMR_CMP_RESET;
    end else if (wr_b_low) begin
      buf_b_q[7:0] <= wdata_i;
    end else if (wr_b_high) begin
      buf_b_q[15:8] <= wdata_i;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pend_b_q <= 1'b0;
    end else if (wr_b_high) begin
      pend_b_q <= 1'b1;
    end else if (src_tick) begin
      pend_b_q <= 1'b0;
    end
  end

  // buffered load has priority over a capture
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      compare_b_o <= `TMR_CMP_RESET;
    end else if (pend_b_q && src_tick) begin
      compare_b_o <= buf_b_q;
    end else if (capture_now) begin
      compare_b_o <= counter_o;
    end
  end

  // ==========================================================
  // up-counter: cleared while stopped and on a match with a
  logic cnt_match;

  assign cnt_match = counter_o == compare_a_o;

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      counter_o <= `TMR_CNT_ZERO;
    end else if (!running) begin
      counter_o <= `TMR_CNT_ZERO;
    end else if (src_tick) begin
      counter_o <= cnt_match ? `TMR_CNT_ZERO : counter_o + `TMR_CNT_ONE;
    end
  end

  // ==========================================================
  // pulse output: preset from flip-flop control while stopped
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      programmable_pulse_output_o <= 1'b0;
    end else if (!running || !pulse_mode) begin
      programmable_pulse_output_o <= flipflop_control;
    end else if (src_tick && (cnt_match || counter_o == compare_b_o)) begin
      programmable_pulse_output_o <= !programmable_pulse_output_o;
    end
  end

  // ==========================================================
  // read port, data one cycle after the strobe
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= `TMR_RDATA_NONE;
    end else if (rd_i) begin
      case (addr_i)
        `TMR_ADDR_A_LOW:  rdata_o <= buf_a_q[7:0];
        `TMR_ADDR_A_HIGH: rdata_o <= buf_a_q[15:8];
        `TMR_ADDR_B_LOW:  rdata_o <= compare_b_o[7:0];
        `TMR_ADDR_B_HIGH: rdata_o <= compare_b_o[15:8];
        `TMR_ADDR_CTRL:   rdata_o <= ctrl_q;
        default:          rdata_o <= `TMR_RDATA_NONE;
      endcase
    end else begin
      rdata_o <= `TMR_RDATA_NONE;
    end
  end

  // ==========================================================
  // checks
  a_ctrl_write: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    wr_ctrl && !stop_mode_enter_i |=> ctrl_q == $past(wdata_i))
    else $error("control write not stored");

  a_stop_clear: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    stop_mode_enter_i |=> start_control == 2'b00 ##1 counter_o == 16'h0000)
    else $error("stop entry did not halt the timer");

  a_b_write_gate: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    hit(wr_i, addr_i, `TMR_ADDR_B_HIGH) && !pulse_mode |=> !$rose(pend_b_q) && $stable(buf_b_q))
    else $error("second register written outside pulse mode");

  a_load_tick: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    pend_a_q && src_tick && !wr_a_high |=> compare_a_o == $past(buf_a_q) && !pend_a_q)
    else $error("buffered value not loaded on source tick");

  a_low_only: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    wr_a_low && !pend_a_q |=> $stable(compare_a_o))
    else $error("low byte alone changed the active value");

  a_capture_copy: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    capture_now && !pend_b_q |=> compare_b_o == $past(counter_o))
    else $error("capture missed the counter value");

  a_stopped_zero: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    !running ##1 !running |-> counter_o == 16'h0000)
    else $error("counter not cleared while stopped");

  a_fast_tick: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    src_tick && source_clock_select == 2'b10 && !wr_ctrl ##1
      (source_clock_select == 2'b10 && !wr_ctrl) [*8] |-> src_tick)
    else $error("fc/8 source tick period wrong");

  a_read_ctrl: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    rd_i && addr_i == `TMR_ADDR_CTRL |=> rdata_o == $past(ctrl_q) ##1 rdata_o == 8'h00 || $past(rd_i))
    else $error("control read data wrong");

  a_b_load_tick: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    pend_b_q && src_tick && !wr_b_high |=> compare_b_o == $past(buf_b_q) && !pend_b_q)
    else $error("second buffered value not loaded on source tick");

  a_pulse_preset: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    !running || !pulse_mode |=> programmable_pulse_output_o == $past(flipflop_control))
    else $error("pulse output not preset from flip-flop control");

endmodule : tmr_ctrl

`default_nettype wire

/* sim/tmr_pin_src.sv */
`timescale 1ns/1ps
`default_nettype none

// ==========
// external pulse source driving the timer pin
module tmr_pin_src (
  // clock
  input  wire logic       mclk_i,
  // request from the bench
  input  wire logic       go_i,
  input  wire logic [7:0] count_i,
  input  wire logic       slow_i,
  // pin and status
  output logic            pin_o,
  output logic            busy_o
);
  int left;

  // emit count_i pulses, each level held two or five cycles
  initial begin
    pin_o = 1'b0;
    busy_o = 1'b0;
    forever begin
      @(posedge mclk_i);
      if (go_i && !busy_o) begin
        busy_o <= 1'b1;
        for (left = count_i; left > 0; left--) begin
          pin_o <= 1'b1;
          repeat (slow_i ? 5 : 2) @(posedge mclk_i);
          pin_o <= 1'b0;
          repeat (slow_i ? 5 : 2) @(posedge mclk_i);
        end
        busy_o <= 1'b0;
      end
    end
  end
endmodule : tmr_pin_src

`default_nettype wire

/* sim/tb_timer16_control_regs.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_timer16_control_regs;
  // ==========
  // signals and bench model
  logic        mclk_i, resetn_i, wr_i, rd_i, fs_tick_i, low_opt, slow_mode_i, stop_i, go, slow;
  logic        tick, pulse, pin, busy;
  logic [7:0]  addr_i, wdata_i, rdata_o, cnt, seed, v;
  logic [15:0] cmp_a, cmp_b, ctr, sb, sc;
  logic [15:0] m_ctrl, m_abuf, m_bbuf, m_a, m_b;
  int          miscompares, checks, n, i, j;
  int          cyc = 0;
  int          fsd = 0;
  int          tbl [5][4] = '{'{0, 0, 0, 2048}, '{0, 1, 0, 32}, '{0, 0, 1, 32}, '{1, 0, 0, 128}, '{2, 0, 0, 8}};

  tmr_ctrl dut (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .timer_input_pin_i(pin), .fs_tick_i(fs_tick_i), .low_speed_divider_option_i(low_opt),
    .slow_mode_i(slow_mode_i), .stop_mode_enter_i(stop_i), .compare_a_o(cmp_a), .compare_b_o(cmp_b),
    .counter_o(ctr), .source_tick_o(tick), .programmable_pulse_output_o(pulse)
  );

  tmr_pin_src src (
    .mclk_i(mclk_i), .go_i(go), .count_i(cnt), .slow_i(slow), .pin_o(pin), .busy_o(busy)
  );

  // clock
  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end

  // fs enable every fourth cycle, timeout counter
  always @(posedge mclk_i) begin
    fsd <= (fsd + 1) % 4;
    fs_tick_i <= (fsd == 3);
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      miscompares++;
      give_verdict();
    end
  end

  // ==========
  // helpers
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // register write, model updated alongside
  task automatic mw(input logic [7:0] a, input logic [7:0] d);
    if (a == 8'h10) m_abuf[7:0] = d;
    if (a == 8'h11) m_abuf[15:8] = d;
    if (a == 8'h12 && m_ctrl[1:0] == 2'b11) m_bbuf[7:0] = d;
    if (a == 8'h13 && m_ctrl[1:0] == 2'b11) m_bbuf[15:8] = d;
    if (a == 8'h26) m_ctrl = {8'h00, d};
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    @(posedge mclk_i);
  endtask : mw

  // register read compared with expectation
  task automatic rchk(input string nm, input logic [7:0] a, input logic [15:0] e);
    logic [7:0] d;
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
    chk(nm, {8'h00, d}, e);
    @(posedge mclk_i);
  endtask : rchk

  // wait for a source tick, snapshot state, return cycles waited
  task automatic wt(output int p);
    p = 0;
    do begin
      @(negedge mclk_i);
      sb = cmp_b;
      sc = ctr;
      p++;
    end while (tick !== 1'b1 && p < 5000);
    if (p >= 5000) chk("tick wait", 16'h0000, 16'h0001);
    @(posedge mclk_i);
  endtask : wt

  // two ticks, then buffers count as loaded
  task automatic ld();
    wt(n);
    wt(n);
    m_a = m_abuf;
    m_b = m_bbuf;
  endtask : ld

  task automatic give_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict

  // ==========
  // main sequence
  initial begin
    {resetn_i, wr_i, rd_i, low_opt, slow_mode_i, stop_i, go, slow} = '0;
    {addr_i, wdata_i, cnt} = '0;
    {miscompares, checks} = '0;
    seed = 8'h0c;
    m_ctrl = 16'h0000;
    {m_abuf, m_bbuf, m_a, m_b} = {4{16'hffff}};
    repeat (6) @(posedge mclk_i);
    resetn_i <= 1'b1;
    @(posedge mclk_i);
    chk("cmp_a reset", cmp_a, 16'hffff);
    chk("cmp_b reset", cmp_b, 16'hffff);
    chk("pulse reset", {15'h0, pulse}, 16'h0000);
    rchk("ctrl reset", 8'h26, 16'h0000);
    for (i = 0; i < 4; i++) rchk("byte reset", 8'(8'h10 + i), 16'h00ff);
    rchk("unmapped", 8'h27, 16'h0000);
    $display("test reset done");
    // random control values, start kept at stop
    for (i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      v = seed & 8'hcf;
      if (v[7]) v = v | 8'h03;
      mw(8'h26, v);
      rchk("ctrl rw", 8'h26, m_ctrl);
      chk("ff level", {15'h0, pulse}, {15'h0, v[7]});
    end
    $display("test control done");
    // second register refused outside pulse mode
    mw(8'h26, 8'h08);
    mw(8'h12, 8'h34);
    mw(8'h13, 8'h12);
    ld();
    chk("cmp_b refused", cmp_b, m_b);
    rchk("b high", 8'h13, {8'h00, m_b[15:8]});
    // low byte alone never loads, high byte then loads on a tick
    mw(8'h10, 8'h04);
    wt(n);
    wt(n);
    wt(n);
    chk("cmp_a low only", cmp_a, 16'hffff);
    rchk("a low buffer", 8'h10, 16'h0004);
    mw(8'h11, 8'h00);
    ld();
    chk("cmp_a load", cmp_a, m_a);
    $display("test buffers done");
    // pulse mode accepts the second register
    mw(8'h26, 8'h0b);
    mw(8'h12, 8'h02);
    mw(8'h13, 8'h00);
    ld();
    chk("cmp_b pulse", cmp_b, m_b);
    rchk("b low", 8'h12, 16'h0002);
    mw(8'h26, 8'h8b);
    @(posedge mclk_i);
    chk("ff set", {15'h0, pulse}, 16'h0001);
    mw(8'h26, 8'h00);
    $display("test pulse mode done");
    // source clock periods
    for (i = 0; i < 5; i++) begin
      low_opt <= tbl[i][1][0];
      slow_mode_i <= tbl[i][2][0];
      mw(8'h26, m_ctrl[7:0] & 8'hcf);
      mw(8'h26, 8'(tbl[i][0] << 2));
      mw(8'h26, 8'((tbl[i][0] << 2) | 8'h10));
      wt(n);
      wt(n);
      chk("tick period", 16'(n), 16'(tbl[i][3]));
    end
    low_opt <= 1'b0;
    slow_mode_i <= 1'b0;
    $display("test source done");
    // auto-capture while counting to compare A
    mw(8'h26, 8'h08);
    mw(8'h26, 8'h48);
    mw(8'h26, 8'h58);
    for (j = 0; j < 10; j++) begin
      wt(n);
      chk("capture", sb, (sc == 16'h0) ? m_a : sc - 16'h1);
      chk("count bound", {15'h0, sc <= m_a}, 16'h0001);
    end
    rchk("b run", 8'h13, 16'h0000);
    mw(8'h10, 8'h20);
    mw(8'h11, 8'h00);
    ld();
    chk("cmp_a running", cmp_a, m_a);
    // stop power mode clears start control
    stop_i <= 1'b1;
    @(posedge mclk_i);
    stop_i <= 1'b0;
    m_ctrl = m_ctrl & 16'h00cf;
    rchk("ctrl stop", 8'h26, m_ctrl);
    chk("counter stop", ctr, 16'h0000);
    $display("test capture and stop done");
    // pin as source, rising then falling edges
    for (j = 0; j < 2; j++) begin
      mw(8'h26, 8'h0c);
      mw(8'h26, 8'(8'h2c + 16 * j));
      seed = lfsr(seed);
      cnt <= 8'(seed[3:0] + 2);
      slow <= seed[0];
      go <= 1'b1;
      @(posedge mclk_i);
      go <= 1'b0;
      repeat (3) @(posedge mclk_i);
      while (busy === 1'b1) @(posedge mclk_i);
      repeat (3) @(posedge mclk_i);
      chk("pin count", ctr, 16'(cnt));
    end
    $display("test pin done");
    give_verdict();
  end
endmodule : tb_timer16_control_regs

`default_nettype wire
